// ---- rtl/pump_ctrl_pkg.sv ----
package pump_ctrl_pkg;
   localparam int CLOCK_HZ = 20_000_000;
   // Internal time base tick period
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = (CLOCK_HZ / 1000) * TICK_MS;
   localparam int TICK_W = 15;
   localparam int LEVEL_W = 8;
   localparam int TIME_W = 16;
   localparam int SRC_W = 3;
   localparam int EVT_BIT = 7;
   localparam logic [SRC_W-1:0] SRC_GEN = 3'h0;
   localparam logic [SRC_W-1:0] SRC_LOADS = 3'h2;
   localparam logic [SRC_W-1:0] SRC_MAINS = 3'h3;
   localparam logic [SRC_W-1:0] SRC_ALWAYS = 3'h4;
   typedef enum logic [1:0] {
      MODE_AUTO = 2'b00,
      MODE_RUN = 2'b01,
      MODE_HALT = 2'b10
   } mode_t;
   typedef enum logic [1:0] {
      POS_HYST = 2'b00,
      POS_START = 2'b01,
      POS_STOP = 2'b10
   } pos_t;
endpackage

// ---- rtl/reductant_pump_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module reductant_pump_control
   import pump_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Configuration
   input wire logic [1:0] i_mode_setting,
   input wire logic i_mode_load,
   input wire logic [SRC_W-1:0] i_power_source,
   input wire logic i_pump_output_function,
   input wire logic i_valve_output_function,
   input wire logic i_contacts_configured,
   input wire logic [LEVEL_W-1:0] i_level_on_threshold,
   input wire logic [LEVEL_W-1:0] i_level_off_threshold,
   input wire logic [TIME_W-1:0] i_valve_delay_ms,
   input wire logic [TIME_W-1:0] i_max_run_ms,
   input wire logic [7:0] i_event_mask,
   // Plant state
   input wire logic i_ctrl_off_reset,
   input wire logic i_generator_ok,
   input wire logic i_loads_ok,
   input wire logic i_mains_ok,
   input wire logic [LEVEL_W-1:0] i_ecu_level,
   // Pins
   input wire logic i_start_level_contact,
   input wire logic i_stop_level_contact,
   input wire logic i_key_up,
   input wire logic i_key_down,
   input wire logic i_key_hold,
   input wire logic i_warning_ack,
   // Outputs
   output logic o_pump_command_state,
   output logic o_valve_command_state,
   output logic o_pump_overrun_warning,
   output logic o_pump_on_event,
   output logic o_pump_off_event,
   output logic [1:0] o_mode,
   output logic o_mode_editing,
   output logic [1:0] o_mode_selection
);
   // Pin synchronisers
   logic [5:0] pin_s1_r, pin_s2_r;
   logic [5:0] pin_raw;
   assign pin_raw = {i_start_level_contact, i_stop_level_contact,
                     i_key_up, i_key_down, i_key_hold, i_warning_ack};
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         pin_s1_r <= 6'h00;
         pin_s2_r <= 6'h00;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
      end
   end
   logic c_start, c_stop, k_up, k_down, k_hold, k_ack;
   assign {c_start, c_stop, k_up, k_down, k_hold, k_ack} = pin_s2_r;
   logic k_up_d_r, k_down_d_r, k_ack_d_r;
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         k_up_d_r <= 1'b0;
         k_down_d_r <= 1'b0;
         k_ack_d_r <= 1'b0;
      end else begin
         k_up_d_r <= k_up;
         k_down_d_r <= k_down;
         k_ack_d_r <= k_ack;
      end
   end
   logic up_press, down_press, ack_press;
   assign up_press = k_up & ~k_up_d_r;
   assign down_press = k_down & ~k_down_d_r;
   assign ack_press = k_ack & ~k_ack_d_r;

   // Millisecond tick
   logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
   logic tick;
   assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
   always_comb begin
      tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) tick_cnt_r <= '0;
      else tick_cnt_r <= tick_cnt_nxt;
   end

   // Mode register and panel editing
   mode_t mode_r, mode_nxt;
   logic edit_r, edit_nxt;
   logic [1:0] sel_r, sel_nxt;
   function automatic logic [1:0] step_mode(input logic [1:0] m,
                                            input logic up);
      if (up) step_mode = (m == 2'h2) ? 2'h0 : m + 2'h1;
      else step_mode = (m == 2'h0) ? 2'h2 : m - 2'h1;
   endfunction
   always_comb begin
      mode_nxt = mode_r;
      edit_nxt = edit_r;
      sel_nxt = sel_r;
      if (i_mode_load && i_mode_setting != 2'h3)
         mode_nxt = mode_t'(i_mode_setting);
      if (!i_pump_output_function) begin
         edit_nxt = 1'b0;
      end else if (!edit_r) begin
         if (k_hold && down_press) begin
            edit_nxt = 1'b1;
            sel_nxt = mode_r;
         end
      end else if (k_hold && down_press) begin
         edit_nxt = 1'b0;
         mode_nxt = mode_t'(sel_r);
      end else if (k_hold && up_press) begin
         edit_nxt = 1'b0;
      end else if (up_press || down_press) begin
         sel_nxt = step_mode(sel_r, up_press);
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         mode_r <= MODE_AUTO;
         edit_r <= 1'b0;
         sel_r <= 2'h0;
      end else begin
         mode_r <= mode_nxt;
         edit_r <= edit_nxt;
         sel_r <= sel_nxt;
      end
   end

   // Level position
   pos_t pos;
   always_comb begin
      if (i_contacts_configured) begin
         if (c_start) pos = POS_START;
         else if (!c_stop) pos = POS_STOP;
         else pos = POS_HYST;
      end else begin
         if (i_ecu_level < i_level_on_threshold) pos = POS_START;
         else if (i_ecu_level > i_level_off_threshold) pos = POS_STOP;
         else pos = POS_HYST;
      end
   end

   // Power source
   logic source_ok;
   always_comb begin
      unique case (i_power_source)
         SRC_GEN: source_ok = i_generator_ok;
         SRC_LOADS: source_ok = i_loads_ok;
         SRC_MAINS: source_ok = i_mains_ok;
         SRC_ALWAYS: source_ok = 1'b1;
         default: source_ok = 1'b0;
      endcase
   end

   // Demand, valve, delay, run timer
   logic demand_r, demand_nxt;
   logic valve_r, valve_nxt;
   logic pump_r, pump_nxt;
   logic warn_r, warn_nxt;
   logic [TIME_W-1:0] vdly_r, vdly_nxt;
   logic [TIME_W-1:0] run_r, run_nxt;
   logic on_evt_r, on_evt_nxt, off_evt_r, off_evt_nxt;
   logic permit;
   assign permit = source_ok & ~i_ctrl_off_reset & i_pump_output_function
                   & ~warn_r;
   always_comb begin
      demand_nxt = demand_r;
      unique case (mode_r)
         MODE_AUTO: begin
            if (pos == POS_START) demand_nxt = 1'b1;
            else if (pos == POS_STOP) demand_nxt = 1'b0;
         end
         MODE_RUN: demand_nxt = (pos != POS_STOP);
         MODE_HALT: demand_nxt = 1'b0;
         default: demand_nxt = 1'b0;
      endcase
      valve_nxt = demand_nxt & permit & i_valve_output_function;
      vdly_nxt = '0;
      if (valve_r && valve_nxt) begin
         vdly_nxt = vdly_r;
         if (tick && vdly_r != i_valve_delay_ms) vdly_nxt = vdly_r + 1'b1;
      end
      pump_nxt = demand_nxt & permit &
                 (!i_valve_output_function ||
                  (valve_r && vdly_r == i_valve_delay_ms));
      run_nxt = '0;
      if (pump_r) run_nxt = (tick && run_r != '1) ? run_r + 1'b1 : run_r;
      warn_nxt = warn_r;
      if (pump_r && run_r >= i_max_run_ms && i_max_run_ms != '0)
         warn_nxt = 1'b1;
      else if (ack_press) warn_nxt = 1'b0;
      if (warn_nxt) begin
         pump_nxt = 1'b0;
         valve_nxt = 1'b0;
      end
      on_evt_nxt = pump_nxt & ~pump_r & i_event_mask[EVT_BIT];
      off_evt_nxt = ~pump_nxt & pump_r & i_event_mask[EVT_BIT];
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         demand_r <= 1'b0;
         valve_r <= 1'b0;
         pump_r <= 1'b0;
         warn_r <= 1'b0;
         vdly_r <= '0;
         run_r <= '0;
         on_evt_r <= 1'b0;
         off_evt_r <= 1'b0;
      end else begin
         demand_r <= demand_nxt;
         valve_r <= valve_nxt;
         pump_r <= pump_nxt;
         warn_r <= warn_nxt;
         vdly_r <= vdly_nxt;
         run_r <= run_nxt;
         on_evt_r <= on_evt_nxt;
         off_evt_r <= off_evt_nxt;
      end
   end

   assign o_pump_command_state = pump_r;
   assign o_valve_command_state = valve_r;
   assign o_pump_overrun_warning = warn_r;
   assign o_pump_on_event = on_evt_r;
   assign o_pump_off_event = off_evt_r;
   assign o_mode = mode_r;
   assign o_mode_editing = edit_r;
   assign o_mode_selection = sel_r;

   sequence s_pump_rise;
      !pump_r ##1 pump_r;
   endsequence
   a_halt_off: assert property (
      @(posedge i_clock) disable iff (i_srst)
      mode_r == MODE_HALT |=> !pump_r)
      else $error("pump on in halt mode");
   a_offreset_off: assert property (
      @(posedge i_clock) disable iff (i_srst)
      i_ctrl_off_reset |=> !pump_r)
      else $error("pump on in off reset");
   a_source_gate: assert property (
      @(posedge i_clock) disable iff (i_srst)
      !source_ok |=> !pump_r)
      else $error("pump on without source");
   a_func_gate: assert property (
      @(posedge i_clock) disable iff (i_srst)
      !i_pump_output_function |=> !pump_r)
      else $error("pump on without output function");
   a_valve_first: assert property (
      @(posedge i_clock) disable iff (i_srst)
      (pump_r && i_valve_output_function) |-> valve_r)
      else $error("pump on without valve");
   a_run_stop: assert property (
      @(posedge i_clock) disable iff (i_srst)
      (mode_r == MODE_RUN && pos == POS_STOP) |=> !demand_r)
      else $error("manual run ignored stop");
   a_warn_stops: assert property (
      @(posedge i_clock) disable iff (i_srst)
      warn_r |-> !pump_r)
      else $error("pump runs during overrun warning");
   a_on_event: assert property (
      @(posedge i_clock) disable iff (i_srst)
      (s_pump_rise ##0 $past(i_event_mask[EVT_BIT])) |-> on_evt_r)
      else $error("missing pump on event");
   a_timer_clear: assert property (
      @(posedge i_clock) disable iff (i_srst)
      !pump_r |=> run_r == '0)
      else $error("run timer not cleared");
endmodule // reductant_pump_control
`default_nettype wire

// ---- verification/plant_level_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module plant_level_model (
   // Tank level
   input wire logic [7:0] i_level,
   // Contacts, high while closed
   output logic o_start_contact,
   output logic o_stop_contact
);
   localparam logic [7:0] START_LVL = 8'h32;
   localparam logic [7:0] STOP_LVL = 8'hc8;
   assign o_start_contact = i_level < START_LVL;
   assign o_stop_contact = i_level < STOP_LVL;
endmodule // plant_level_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import pump_ctrl_pkg::*;
;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [1:0] mode_set = 2'h0;
   logic mode_load = 1'b1;
   logic [2:0] src = 3'h4;
   logic pump_fn = 1'b1, valve_fn = 1'b0, contacts = 1'b1;
   logic [7:0] lvl = 8'h64, ecu = 8'h64, mask = 8'h80;
   logic [15:0] vdelay = 16'h0000, maxrun = 16'h0000;
   logic off_rst = 1'b0, gen_ok = 1'b1, loads_ok = 1'b1, mains_ok = 1'b1;
   logic k_up = 1'b0, k_dn = 1'b0, k_hold = 1'b0, ack = 1'b0;
   logic start_c, stop_c, pump, valve, warn, ev_on, ev_off, editing;
   logic [1:0] mode, sel;
   logic [2:0] srcs [4] = '{SRC_GEN, SRC_LOADS, SRC_MAINS, SRC_ALWAYS};
   int err_count = 0, num_checks = 0, n_on = 0, n_off = 0;

   plant_level_model plant (.i_level(lvl), .o_start_contact(start_c),
      .o_stop_contact(stop_c));

   reductant_pump_control DUT (.i_clock(clock), .i_srst(srst),
      .i_mode_setting(mode_set), .i_mode_load(mode_load),
      .i_power_source(src), .i_pump_output_function(pump_fn),
      .i_valve_output_function(valve_fn), .i_contacts_configured(contacts),
      .i_level_on_threshold(8'h32), .i_level_off_threshold(8'hc8),
      .i_valve_delay_ms(vdelay), .i_max_run_ms(maxrun),
      .i_event_mask(mask), .i_ctrl_off_reset(off_rst),
      .i_generator_ok(gen_ok), .i_loads_ok(loads_ok),
      .i_mains_ok(mains_ok), .i_ecu_level(ecu),
      .i_start_level_contact(start_c), .i_stop_level_contact(stop_c),
      .i_key_up(k_up), .i_key_down(k_dn), .i_key_hold(k_hold),
      .i_warning_ack(ack), .o_pump_command_state(pump),
      .o_valve_command_state(valve), .o_pump_overrun_warning(warn),
      .o_pump_on_event(ev_on), .o_pump_off_event(ev_off), .o_mode(mode),
      .o_mode_editing(editing), .o_mode_selection(sel));

   initial begin
      forever #25 clock = ~clock;
   end

   always @(posedge clock) begin
      if (ev_on === 1'b1) n_on <= n_on + 1;
      if (ev_off === 1'b1) n_off <= n_off + 1;
   end

   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic wait_pump(input logic exp, input int lim);
      int i;
      i = 0;
      while (pump !== exp && i < lim) begin
         @(posedge clock);
         i++;
      end
      chk(pump, exp);
   endtask

   task automatic press(input logic u, input logic d, input logic h);
      k_up <= u;
      k_dn <= d;
      k_hold <= h;
      cyc(5);
      k_up <= 1'b0;
      k_dn <= 1'b0;
      k_hold <= 1'b0;
      cyc(5);
   endtask

   initial begin
      repeat (90000) @(posedge clock);
      err_count++;
      report_and_stop();
   end

   initial begin
      cyc(10);
      srst <= 1'b0;
      cyc(5);
      lvl <= 8'h0a;
      wait_pump(1'b1, 20);
      cyc(2);
      chk(16'(n_on), 16'h0001);
      lvl <= 8'h64;
      cyc(10);
      chk(pump, 16'h0001);
      lvl <= 8'hfa;
      wait_pump(1'b0, 20);
      cyc(2);
      chk(16'(n_off), 16'h0001);
      lvl <= 8'h64;
      cyc(10);
      chk(pump, 16'h0000);
      mask <= 8'h00;
      lvl <= 8'h0a;
      wait_pump(1'b1, 20);
      lvl <= 8'hfa;
      wait_pump(1'b0, 20);
      chk(16'(n_on), 16'h0001);
      mask <= 8'h80;
      contacts <= 1'b0;
      ecu <= 8'h0a;
      wait_pump(1'b1, 20);
      ecu <= 8'hfa;
      wait_pump(1'b0, 20);
      contacts <= 1'b1;
      ecu <= 8'h0a;
      cyc(10);
      chk(pump, 16'h0000);
      mode_set <= MODE_RUN;
      lvl <= 8'h64;
      wait_pump(1'b1, 20);
      chk(mode, MODE_RUN);
      lvl <= 8'hfa;
      wait_pump(1'b0, 20);
      lvl <= 8'h64;
      wait_pump(1'b1, 20);
      mode_set <= MODE_HALT;
      lvl <= 8'h0a;
      wait_pump(1'b0, 20);
      cyc(10);
      chk(pump, 16'h0000);
      mode_set <= MODE_AUTO;
      wait_pump(1'b1, 20);
      for (int s = 0; s < 4; s++) begin
         src <= srcs[s];
         gen_ok <= s != 0;
         loads_ok <= s != 1;
         mains_ok <= s != 2;
         wait_pump(s == 3, 20);
         chk(mode, MODE_AUTO);
         cyc(2);
         gen_ok <= s == 0;
         loads_ok <= s == 1;
         mains_ok <= s == 2;
         wait_pump(1'b1, 20);
      end
      src <= 3'h1;
      wait_pump(1'b0, 20);
      src <= SRC_ALWAYS;
      wait_pump(1'b1, 20);
      off_rst <= 1'b1;
      wait_pump(1'b0, 20);
      off_rst <= 1'b0;
      wait_pump(1'b1, 20);
      pump_fn <= 1'b0;
      wait_pump(1'b0, 20);
      pump_fn <= 1'b1;
      lvl <= 8'hfa;
      cyc(6);
      wait_pump(1'b0, 20);
      valve_fn <= 1'b1;
      vdelay <= 16'h0002;
      lvl <= 8'h0a;
      cyc(10);
      chk(valve, 16'h0001);
      chk(pump, 16'h0000);
      wait_pump(1'b1, 40100);
      valve_fn <= 1'b0;
      maxrun <= 16'h0001;
      wait_pump(1'b0, 40010);
      chk(warn, 16'h0001);
      chk(mode, MODE_AUTO);
      maxrun <= 16'h0000;
      ack <= 1'b1;
      cyc(5);
      ack <= 1'b0;
      wait_pump(1'b1, 20);
      chk(warn, 16'h0000);
      mode_set <= 2'h3;
      cyc(3);
      chk(mode, MODE_AUTO);
      mode_load <= 1'b0;
      press(1'b0, 1'b1, 1'b1);
      chk(editing, 16'h0001);
      chk(sel, MODE_AUTO);
      press(1'b0, 1'b1, 1'b0);
      press(1'b1, 1'b0, 1'b1);
      chk(editing, 16'h0000);
      chk(mode, MODE_AUTO);
      press(1'b0, 1'b1, 1'b1);
      press(1'b0, 1'b1, 1'b0);
      press(1'b0, 1'b1, 1'b1);
      chk(editing, 16'h0000);
      chk(mode != MODE_AUTO, 16'h0001);
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
